/* spi_link_pkg.sv */
/*
 * Shared constants for the serial peripheral slave link: frame layout,
 * check bytes, pacing limits and the master's clock divider.
 * Assumes both ends compile against this package.
 */
`default_nettype none
package spi_link_pkg;
	localparam int FRAME_BYTES = 10;
	localparam int BYTE_BITS   = 8;
	localparam logic [7:0] REQ_FIRST      = 8'h01;
	localparam logic [7:0] REQ_STATUS_CHK = 8'hD4;
	localparam logic [7:0] FOLLOW_FIRST   = 8'h02;
	localparam logic [7:0] FOLLOW_CHK     = 8'h51;
	localparam logic [7:0] RSP_FIRST      = 8'h01;
	localparam logic [7:0] RSP_SECOND     = 8'h4B;
	localparam logic [7:0] RSP_CHK        = 8'h0A;
	localparam logic [7:0] FILL_BYTE      = 8'h00;
	localparam logic [7:0] REQ_OBJ_LO     = 8'h41;
	localparam logic [7:0] REQ_OBJ_HI     = 8'h60;
	localparam int CLK_PERIOD_NS   = 40;
	localparam int SCLK_MAX_KHZ    = 20000;
	localparam int SCLK_HALF_CYC   = 1;
	localparam int GAP_UNSYNC_US   = 2000;
	localparam int GAP_SYNC_US     = 1000;
	localparam int GAP_UNSYNC_CYC  = (GAP_UNSYNC_US * 1000) / CLK_PERIOD_NS;
	localparam int GAP_SYNC_CYC    = (GAP_SYNC_US * 1000) / CLK_PERIOD_NS;
	localparam logic [3:0] BYTE_IDX_RESET = 4'h0;
	localparam logic [2:0] BIT_IDX_RESET  = 3'h7;
endpackage : spi_link_pkg
`default_nettype wire

/* spi_link_if.sv */
/*
 * Four-wire serial link between master and slave.
 * Assumes the master end makes sclk and the select.
 */
`default_nettype none
interface spi_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	modport master (output sclk, output cs_n, output mosi, input miso);
	modport slave  (input sclk, input cs_n, input mosi, output miso);
endinterface : spi_link_if
`default_nettype wire

/* spi_link_master.sv */
/*
 * Master end: sends one ten-byte frame per start pulse, paces frames.
 * Assumes start, tx bytes and rst come from logic on mclk.
 */
`default_nettype none
module spi_link_master
	import spi_link_pkg::*;
#(
	parameter int GAP_UNSYNC = GAP_UNSYNC_CYC,
	parameter int GAP_SYNC   = GAP_SYNC_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	spi_link_if.master      link,
	input  wire logic       start,
	input  wire logic       synced,
	input  wire logic [7:0] tx_byte [FRAME_BYTES],
	output logic            busy,
	output logic            done,
	output logic [7:0]      rx_byte [FRAME_BYTES]
);
	typedef enum logic [1:0] {M_IDLE, M_RUN, M_GAP} mstate_t;
	mstate_t     state;
	logic [3:0]  byte_idx;
	logic [2:0]  bit_idx;
	logic        phase;
	logic [31:0] gap_cnt;
	logic        miso_s1;
	logic        miso_s2;
	logic        cap_en;
	logic        cap_last;
	logic [3:0]  cap_byte;
	logic [2:0]  cap_bit;

	assign busy = (state != M_IDLE);

	always_ff @(posedge mclk) begin
		miso_s1 <= link.miso;
		miso_s2 <= miso_s1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state     <= M_IDLE;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
			link.mosi <= 1'b0;
			byte_idx  <= BYTE_IDX_RESET;
			bit_idx   <= BIT_IDX_RESET;
			phase     <= 1'b0;
			gap_cnt   <= '0;
		end else begin
			case (state)
			M_IDLE: begin
				link.sclk <= 1'b0;
				if (start) begin
					state     <= M_RUN;
					link.cs_n <= 1'b0;
					byte_idx  <= BYTE_IDX_RESET;
					bit_idx   <= BIT_IDX_RESET;
					phase     <= 1'b0;
				end
			end
			M_RUN: begin
				// Clock is mclk/4, well below the 20 MHz ceiling
				phase <= ~phase;
				if (!phase) begin
					if (!link.sclk) begin
						link.sclk <= 1'b1;
						link.mosi <= tx_byte[byte_idx][bit_idx];
					end else begin
						link.sclk <= 1'b0;
						if (bit_idx == 3'h0) begin
							bit_idx <= BIT_IDX_RESET;
							if (byte_idx == 4'(FRAME_BYTES - 1)) begin
								state     <= M_GAP;
								gap_cnt   <= synced ? 32'(GAP_SYNC) :
									32'(GAP_UNSYNC);
							end else begin
								byte_idx <= byte_idx + 4'h1;
							end
						end else begin
							bit_idx <= bit_idx - 3'h1;
						end
					end
				end
			end
			M_GAP: begin
				// Select rises one edge after the last falling sclk, so the
				// slave still sees itself selected at that edge
				link.cs_n <= 1'b1;
				if (gap_cnt <= 32'h1)
					state <= M_IDLE;
				gap_cnt <= gap_cnt - 32'h1;
			end
			default: state <= M_IDLE;
			endcase
		end
	end

	// The second stage shows a bit only at the mclk edge where sclk falls, so the
	// capture waits an edge, and done waits for the last bit to land.
	always_ff @(posedge mclk) begin
		if (rst) begin
			cap_en   <= 1'b0;
			cap_last <= 1'b0;
			cap_byte <= BYTE_IDX_RESET;
			cap_bit  <= BIT_IDX_RESET;
			done     <= 1'b0;
		end else begin
			cap_en   <= (state == M_RUN) && !phase && link.sclk;
			cap_last <= (bit_idx == 3'h0) &&
				(byte_idx == 4'(FRAME_BYTES - 1));
			cap_byte <= byte_idx;
			cap_bit  <= bit_idx;
			done     <= cap_en && cap_last;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < FRAME_BYTES; i++)
				rx_byte[i] <= FILL_BYTE;
		end else if (cap_en) begin
			rx_byte[cap_byte][cap_bit] <= miso_s2;
		end
	end
endmodule : spi_link_master
`default_nettype wire

/* spi_link_slave.sv */
/*
 * Slave end of the serial link, clocked by the link's sclk, with the
 * status word read straight from the mclk domain, with no synchroniser.
 * Assumes sclk idles low and stands still outside frames.
 */
`default_nettype none
// How it works
// - Master keeps clock low when idle
// - Outgoing bit driven on rising edge
// - Incoming bit sampled on falling edge
// - Most significant bit goes first
// - Select is active low, gates transfer
// - Unsynced master: one message per 2 ms
// - Synced master: one message per ms
// - Master clock at most 20 MHz
// - No valid reply before first good message
// - First good message completes bus initialisation
// - Master tests with status read, follow-up
// - Status reply 01 4B, status, 0A
// - Jumper high: fieldbus on, else link
module spi_link_slave
	import spi_link_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	spi_link_if.slave        link,
	input  wire logic        link_select_jumper,
	input  wire logic [15:0] status_word,
	output logic             fieldbus_select_in,
	output logic             comm_link_select_n,
	output logic             init_done,
	output logic             frame_seen
);
	logic       jmp_s1;
	logic       jmp_s2;
	logic       link_on;
	logic [3:0] rx_byte_idx;
	logic [2:0] rx_bit_idx;
	logic [7:0] shift_in;
	logic       req_ok;
	logic       is_status;
	logic       frame_ok;
	logic       init_sck;
	logic [7:0] rsp [FRAME_BYTES];
	logic [7:0] tx_byte;
	logic       frame_tgl;
	logic [2:0] tgl_sync;
	logic       init_s1;
	logic       init_s2;
	logic       cs_active;
	logic [7:0] next_shift;
	logic       last_bit;

	// First byte opens either the status read or the follow-up frame
	function automatic logic first_ok(input logic [7:0] b);
		first_ok = (b == REQ_FIRST) || (b == FOLLOW_FIRST);
	endfunction : first_ok

	// Check byte must match the kind of frame that the first byte
	// opened; a follow-up closed with the status check byte is refused.
	function automatic logic check_ok(input logic [7:0] b,
		input logic status_frame);
		if (status_frame)
			check_ok = (b == REQ_STATUS_CHK);
		else
			check_ok = (b == FOLLOW_CHK);
	endfunction : check_ok

	// Open input reads low, so an absent jumper selects the link.
	// The jumper is a pin, hence the two flip-flops before any use.
	always_ff @(posedge mclk) begin
		jmp_s1 <= link_select_jumper;
		jmp_s2 <= jmp_s1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			fieldbus_select_in <= 1'b0;
			comm_link_select_n <= 1'b1;
		end else begin
			fieldbus_select_in <= jmp_s2;
			comm_link_select_n <= jmp_s2;
		end
	end

	// The link select is quasi-static: it is set by a jumper and only
	// read inside frames, so it is used in the sclk domain directly.
	// Changing the jumper in mid-frame may cut that frame short.
	assign link_on   = !comm_link_select_n;
	assign cs_active = !link.cs_n && link_on;

	// Byte as it stands once the current falling edge has shifted in
	assign next_shift = {shift_in[6:0], link.mosi};
	assign last_bit   = (rx_byte_idx == 4'(FRAME_BYTES - 1)) &&
		(rx_bit_idx == 3'h0);
	assign frame_ok   = last_bit && req_ok && cs_active &&
		check_ok(next_shift, is_status);

	// Receive on falling sclk; select high resets counters asynchronously
	// to the stopped sclk, so each frame starts at byte zero.
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			rx_byte_idx <= BYTE_IDX_RESET;
			rx_bit_idx  <= BIT_IDX_RESET;
			shift_in    <= FILL_BYTE;
			req_ok      <= 1'b1;
			is_status   <= 1'b0;
		end else begin
			shift_in   <= next_shift;
			rx_bit_idx <= rx_bit_idx - 3'h1;
			if (rx_bit_idx == 3'h0) begin
				rx_byte_idx <= rx_byte_idx + 4'h1;
				if (rx_byte_idx == 4'h0) begin
					req_ok    <= first_ok(next_shift);
					is_status <= next_shift == REQ_FIRST;
				end
			end
		end
	end

	// Init flag is set at the last falling edge of the first good frame,
	// while select is still low. A flag kept under the select's reset
	// would be gone before the next frame, and sclk stands still after
	// the frame, so no later edge can be relied on. Only rst clears it.
	always_ff @(negedge link.sclk or posedge rst) begin
		if (rst) begin
			init_sck  <= 1'b0;
			frame_tgl <= 1'b0;
		end else if (frame_ok && !init_sck) begin
			init_sck  <= 1'b1;
			frame_tgl <= ~frame_tgl;
		end
	end

	// Reply bytes; each status byte sampled on sclk as its byte loads (it
	// changes slowly, a torn read of two bytes is tolerated).
	always_comb begin
		for (int i = 0; i < FRAME_BYTES; i++)
			rsp[i] = FILL_BYTE;
		if (init_sck) begin
			rsp[0] = RSP_FIRST;
			rsp[1] = RSP_SECOND;
			rsp[2] = REQ_OBJ_LO;
			rsp[3] = REQ_OBJ_HI;
			rsp[5] = status_word[7:0];
			rsp[6] = status_word[15:8];
			rsp[9] = RSP_CHK;
		end
	end

	// Launch on rising sclk; a byte is loaded at its first rising edge,
	// then shifted. Before that, with select high, the line idles at 0.
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n)
			tx_byte <= FILL_BYTE;
		else if (rx_bit_idx == BIT_IDX_RESET)
			tx_byte <= rsp[rx_byte_idx];
		else
			tx_byte <= {tx_byte[6:0], 1'b0};
	end

	// Deselected or disabled, the slave keeps its output at 0 rather
	// than showing a stale bit to another slave's master.
	assign link.miso = cs_active ? tx_byte[7] : 1'b0;

	// Both flags cross from the sclk domain as single bits. The toggle
	// changes once only, so a three-stage chain and an edge detect on
	// the last two stages give a clean one-cycle pulse on mclk.
	always_ff @(posedge mclk) begin
		tgl_sync <= {tgl_sync[1:0], frame_tgl};
		init_s1  <= init_sck;
		init_s2  <= init_s1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			init_done  <= 1'b0;
			frame_seen <= 1'b0;
		end else begin
			init_done  <= init_s2;
			frame_seen <= tgl_sync[2] ^ tgl_sync[1];
		end
	end
endmodule : spi_link_slave
`default_nettype wire

/* spi_link_asserts.sv */
/* Wire checks for the four-wire link.
 * Assumes sclk is made from mclk by the master end. */
`default_nettype none
module spi_link_asserts (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] nrise;
	// Cleared by a high select so every frame counts from zero
	always_ff @(posedge mclk) begin
		if (rst || cs_n)
			nrise <= 8'h00;
		else if ($rose(sclk))
			nrise <= nrise + 8'h01;
	end
	a_idle_clk_low: assert property (cs_n |-> !sclk)
		else $error("sclk high while deselected");
	a_sclk_shape: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("sclk high phase wrong");
	a_cs_lead: assert property ($fell(cs_n) |-> !sclk ##[2:4] sclk)
		else $error("no clock after select");
	a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while sclk high");
	a_miso_hold: assert property (sclk && $past(sclk) |-> $stable(miso))
		else $error("miso moved while sclk high");
	a_frame_bits: assert property ($rose(cs_n) |-> nrise == 8'h50)
		else $error("frame bit count wrong");
	a_frame_gap: assert property ($rose(cs_n) |=> cs_n [*8])
		else $error("frames too close");
	a_fall_in_frame: assert property ($fell(sclk) |-> !cs_n)
		else $error("sclk fell outside frame");
endmodule : spi_link_asserts
`default_nettype wire

/* motion_ctrl_spi_slave_link_tb.sv */
/* Bench joining master and slave ends over one link.
 * Assumes short gap parameters; replies checked by a monitor. */
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module motion_ctrl_spi_slave_link_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spi_link_pkg::*;
	localparam logic [79:0] REQ = {REQ_FIRST, 8'h40, REQ_OBJ_LO,
		REQ_OBJ_HI, 40'h0, REQ_STATUS_CHK};
	localparam logic [79:0] FOL = {FOLLOW_FIRST, 64'h0, FOLLOW_CHK};
	logic        mclk = 1'b0, rst = 1'b1, start = 1'b0;
	logic        synced = 1'b0, jmp = 1'b1;
	logic [15:0] status = 16'h0000;
	logic [7:0]  tx [FRAME_BYTES] = '{default: 8'h00};
	logic [7:0]  rx [FRAME_BYTES];
	logic        busy, done, fsel, lsel_n, init, seen;
	logic [80:0] e, exp_q [$];
	logic [79:0] got;
	int          n_mismatch = 0, checks = 0, n_seen = 0;
	always #20 mclk = ~mclk;
	spi_link_if link_if ();
	spi_link_master #(.GAP_UNSYNC(20), .GAP_SYNC(10)) spi_link_master_inst (
		.mclk(mclk), .rst(rst), .link(link_if.master), .start(start),
		.synced(synced), .tx_byte(tx), .busy(busy), .done(done),
		.rx_byte(rx));
	spi_link_slave spi_link_slave_inst (.mclk(mclk), .rst(rst),
		.link(link_if.slave), .link_select_jumper(jmp),
		.status_word(status), .fieldbus_select_in(fsel),
		.comm_link_select_n(lsel_n), .init_done(init), .frame_seen(seen));
	spi_link_asserts spi_link_asserts_inst (.mclk(mclk), .rst(rst),
		.sclk(link_if.sclk), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
		.miso(link_if.miso));
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	task automatic wait_for(ref logic s, input logic v);
		for (int i = 0; i < 2000 && s !== v; i++)
			@(negedge mclk);
		if (s !== v) begin
			n_mismatch++;
			end_of_test();
		end
	endtask : wait_for
	// Start is only raised once busy has dropped, so pacing stays legal
	task automatic send(input logic [79:0] f, input logic [80:0] x);
		for (int i = 0; i < FRAME_BYTES; i++)
			tx[i] = f[79 - 8 * i -: 8];
		exp_q.push_back(x);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		wait_for(done, 1'b1);
		wait_for(busy, 1'b0);
	endtask : send
	always @(posedge mclk)
		if (seen === 1'b1)
			n_seen++;
	always @(posedge mclk) begin
		if (done === 1'b1) begin
			e = exp_q.pop_front();
			for (int i = 0; i < FRAME_BYTES; i++)
				got[79 - 8 * i -: 8] = rx[i];
			if (e[80])
				`CHK("reply", e[79:0], got)
		end
	end
	initial begin
		void'($urandom(32'h852C79C1));
		tick(12);
		rst = 1'b0;
		tick(4);
		`CHK("fsel", 1'b1, fsel)
		`CHK("lsel_n", 1'b1, lsel_n)
		jmp = 1'b0;
		tick(4);
		`CHK("fsel", 1'b0, fsel)
		`CHK("lsel_n", 1'b0, lsel_n)
		$display("test jumper ends");
		send({8'h03, REQ[71:0]}, {1'b1, 80'h0});
		`CHK("init", 1'b0, init)
		send(REQ, {1'b1, 80'h0});
		`CHK("init", 1'b1, init)
		send(FOL, {1'b1, RSP_FIRST, RSP_SECOND, REQ_OBJ_LO, REQ_OBJ_HI,
			FILL_BYTE, status[7:0], status[15:8], FILL_BYTE, FILL_BYTE,
			RSP_CHK});
		tick(4);
		`CHK("init", 1'b1, init)
		$display("test init ends");
		synced = 1'b1;
		for (int k = 0; k < 3; k++) begin
			status = 16'($urandom());
			tick(8);
			send(REQ, {1'b1, RSP_FIRST, RSP_SECOND, REQ_OBJ_LO, REQ_OBJ_HI,
				FILL_BYTE, status[7:0], status[15:8], FILL_BYTE, FILL_BYTE,
				RSP_CHK});
		end
		`CHK("seen", 1, n_seen)
		$display("test reply ends");
		end_of_test();
	end
endmodule : motion_ctrl_spi_slave_link_tb
`default_nettype wire
